//--- i2c_slave_pkg.sv
// Purpose: Shared constants and types for the tick-stepped I2C slave engine
// Assumes: 25 MHz system clock, plain register port with byte addresses
// Notes:   Register word at byte address = index * 4
package i2c_slave_pkg;

    localparam int CLK_PERIOD_NS = 40;
    localparam int TICK_PERIOD_NS = 1000;
    // Longest step period, rounded down, never below one cycle
    localparam int TICK_CYCLES = (TICK_PERIOD_NS / CLK_PERIOD_NS < 1) ? 1 : TICK_PERIOD_NS / CLK_PERIOD_NS;

    localparam logic [3:0] BIT_COUNT_PRESET = 4'h8;
    localparam int STORE_DEPTH_MAX = 16;

    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_RX_DATA = 8'h08;
    localparam logic [7:0] ADDR_TX_DATA = 8'h0C;
    localparam logic [7:0] ADDR_STORE_COUNT = 8'h10;
    localparam logic [7:0] ADDR_STORE_BASE = 8'h40;

    localparam int CTRL_STORE_MODE_BIT = 8;
    localparam int CTRL_INIT_BIT = 9;
    localparam int ST_RX_BIT = 0;
    localparam int ST_EVENT_BIT = 1;
    localparam int ST_READING_BIT = 2;
    localparam int ST_TX_VALID_BIT = 3;
    localparam int ST_STARVED_BIT = 4;
    localparam int ST_BUSY_BIT = 5;

    localparam logic [6:0] SLAVE_ADDR_RESET = 7'h20;
    localparam logic [4:0] STORE_COUNT_RESET = 5'h10;

    typedef enum logic [11:0] {
        st_quiet             = 12'h001,
        st_await_clock_low   = 12'h002,
        st_prep_addr_capture = 12'h004,
        st_shift_in          = 12'h008,
        st_addr_check        = 12'h010,
        st_drive_ack         = 12'h020,
        st_prep_data_capture = 12'h040,
        st_return_quiet      = 12'h080,
        st_store_rx          = 12'h100,
        st_prep_shift_out    = 12'h200,
        st_shift_out         = 12'h400,
        st_sample_ack        = 12'h800
    } main_state_t;

endpackage

//--- line_sync.sv
// Purpose: Two-flop synchroniser for one bus line sample
// Assumes: Line idles high, so both flops reset high
// Notes:   First flop is read only by the second
`timescale 1ns/1ns
`default_nettype none
module line_sync (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic line_in,
    output logic      line_out
);
    logic meta_reg;

    always_ff @(posedge clk) begin
        if (reset) begin
            meta_reg <= 1'b1;
            line_out <= 1'b1;
        end else begin
            meta_reg <= line_in;
            line_out <= meta_reg;
        end
    end
endmodule // line_sync
`default_nettype wire

//--- i2c_slave_engine.sv
// Purpose: I2C slave engine stepped by a periodic tick, with a register port
// Assumes: Open-drain pins resolved outside; one 25 MHz clock, sync reset
// Notes:   Address byte compare on bits 7:1, direction in bit 0
//
// Functional notes
// [RULE1] Answer only the configured slave address; ignore all others.
// [RULE2] Keep a readable store of at most 16 outgoing words.
// [RULE3] Local logic clears the receive flag after consuming the byte.
// [RULE4] Provide a master-reading indication; low means master writes.
// [RULE5] Local logic loads transmit byte, then sets valid; next read sends it.
// [RULE6] Without valid data on a read, flag starvation and hold SCL low.
// [RULE7] Stay quiet until the start detector sees a start.
// [RULE8] After a start, wait for SCL low before address capture.
// [RULE9] Preset bit counter to 8; advance after eight bits shifted in.
// [RULE10] Check address; choose receive or transmit by direction bit, else quiet.
// [RULE11] Acknowledge by holding SDA low over one master SCL pulse.
// [RULE12] Copy received byte to holding register; set event and receive flags.
// [RULE13] Transmit loaded byte one bit per SCL clock, counter preset to 8.
// [RULE14] After each sent byte, ACK sends next byte, no ACK goes quiet.
// [RULE15] Step on a periodic tick fast enough for a 100 kHz bus.
// [RULE16] Initialisation sets all engine state to known values.
// [RULE17] Start is SDA falling with SCL high; stop is SDA rising with SCL high.
// [RULE18] Bytes move most significant bit first both ways.
// [RULE19] A stop in any state returns to quiet and releases both lines.
// [RULE20] Drive lines only low or released; synchronise both line samples.
`timescale 1ns/1ns
`default_nettype none
module i2c_slave_engine #(
    parameter int STORE_DEPTH = 16
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [31:0] reg_rdata,
    input  wire logic        data_line_pin_in,
    output logic             data_line_pin_out,
    output logic             data_line_pin_oe_n,
    input  wire logic        clock_line_pin_in,
    output logic             clock_line_pin_out,
    output logic             clock_line_pin_oe_n
);
    initial begin
        if (STORE_DEPTH < 1 || STORE_DEPTH > i2c_slave_pkg::STORE_DEPTH_MAX)
            $error("STORE_DEPTH must be 1..16");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Line sampling and step tick
    logic sda_s;
    logic scl_s;
    logic sda_prev_reg;
    logic scl_prev_reg;
    logic [4:0] tick_cnt_reg;
    logic tick;

    line_sync sda_sync (.clk(clk), .reset(reset), .line_in(data_line_pin_in), .line_out(sda_s)); // RULE20
    line_sync scl_sync (.clk(clk), .reset(reset), .line_in(clock_line_pin_in), .line_out(scl_s)); // RULE20

    assign tick = (tick_cnt_reg == 5'(i2c_slave_pkg::TICK_CYCLES - 1)); // RULE15

    always_ff @(posedge clk) begin
        if (reset || tick) tick_cnt_reg <= 5'h00;
        else tick_cnt_reg <= tick_cnt_reg + 5'h01;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            sda_prev_reg <= 1'b1;
            scl_prev_reg <= 1'b1;
        end else if (tick) begin
            sda_prev_reg <= sda_s;
            scl_prev_reg <= scl_s;
        end
    end

    // Bus condition detector, evaluated at step rate on synchronised lines
    wire start_seen = tick && sda_prev_reg && !sda_s && scl_prev_reg && scl_s; // RULE17
    wire stop_seen  = tick && !sda_prev_reg && sda_s && scl_prev_reg && scl_s; // RULE17
    wire scl_rise   = !scl_prev_reg && scl_s;
    wire scl_fall   = scl_prev_reg && !scl_s;

    ////////////////////////////////////////////////////////////////////////////
    // Register port decode
    logic [6:0] slave_addr_reg;
    logic       store_mode_reg;
    logic [4:0] store_count_reg;
    logic [7:0] tx_holding_reg;
    logic [7:0] rx_holding_reg;
    logic       byte_received_flag;
    logic       slave_event_flag;
    logic       tx_valid_flag;
    logic       tx_starved_flag;
    logic       master_reading_flag;
    logic [7:0] store_mem [STORE_DEPTH];

    wire wr_ctrl   = reg_write && (reg_addr == i2c_slave_pkg::ADDR_CTRL);
    wire wr_status = reg_write && (reg_addr == i2c_slave_pkg::ADDR_STATUS);
    wire wr_tx     = reg_write && (reg_addr == i2c_slave_pkg::ADDR_TX_DATA);
    wire wr_count  = reg_write && (reg_addr == i2c_slave_pkg::ADDR_STORE_COUNT);
    wire in_store  = (reg_addr >= i2c_slave_pkg::ADDR_STORE_BASE) &&
                     (reg_addr < i2c_slave_pkg::ADDR_STORE_BASE + 8'(STORE_DEPTH * 4)) &&
                     (reg_addr[1:0] == 2'h0);
    wire [3:0] store_sel = 4'((reg_addr - i2c_slave_pkg::ADDR_STORE_BASE) >> 2);
    // Soft initialisation strobe resets the state machine, flags and receive byte like reset, but not the configuration, transmit byte or tick
    wire engine_initialise = reset || (wr_ctrl && reg_wdata[i2c_slave_pkg::CTRL_INIT_BIT]); // RULE16
    wire clr_rx    = wr_status && reg_wdata[i2c_slave_pkg::ST_RX_BIT]; // RULE3
    wire clr_event = wr_status && reg_wdata[i2c_slave_pkg::ST_EVENT_BIT];
    wire set_valid = wr_status && reg_wdata[i2c_slave_pkg::ST_TX_VALID_BIT]; // RULE5

    i2c_slave_pkg::main_state_t main_state_reg;
    i2c_slave_pkg::main_state_t state_next;
    i2c_slave_pkg::main_state_t after_ack_reg;
    i2c_slave_pkg::main_state_t after_ack_next;

    wire [31:0] status_word = {26'h0000000, (main_state_reg != i2c_slave_pkg::st_quiet), tx_starved_flag,
                               tx_valid_flag, master_reading_flag, slave_event_flag, byte_received_flag};
    wire [31:0] ctrl_word = {23'h000000, store_mode_reg, 1'b0, slave_addr_reg};
    wire [31:0] read_mux =
        (reg_addr == i2c_slave_pkg::ADDR_CTRL)        ? ctrl_word :
        (reg_addr == i2c_slave_pkg::ADDR_STATUS)      ? status_word :
        (reg_addr == i2c_slave_pkg::ADDR_RX_DATA)     ? {24'h000000, rx_holding_reg} :
        (reg_addr == i2c_slave_pkg::ADDR_TX_DATA)     ? {24'h000000, tx_holding_reg} :
        (reg_addr == i2c_slave_pkg::ADDR_STORE_COUNT) ? {27'h0000000, store_count_reg} :
        in_store                                      ? {24'h000000, store_mem[store_sel]} : 32'h00000000;

    always_ff @(posedge clk) begin
        if (reset) reg_rdata <= 32'h00000000;
        else reg_rdata <= reg_read ? read_mux : 32'h00000000;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            slave_addr_reg <= i2c_slave_pkg::SLAVE_ADDR_RESET;
            store_mode_reg <= 1'b0;
            store_count_reg <= i2c_slave_pkg::STORE_COUNT_RESET;
            tx_holding_reg <= 8'h00;
        end else begin
            if (wr_ctrl) slave_addr_reg <= reg_wdata[6:0];
            if (wr_ctrl) store_mode_reg <= reg_wdata[i2c_slave_pkg::CTRL_STORE_MODE_BIT];
            if (wr_count) store_count_reg <= reg_wdata[4:0];
            if (wr_tx) tx_holding_reg <= reg_wdata[7:0]; // RULE5
        end
    end

    // Store words carry no reset; software fills them before use
    always_ff @(posedge clk) begin
        if (reg_write && in_store) store_mem[store_sel] <= reg_wdata[7:0]; // RULE2
    end

    ////////////////////////////////////////////////////////////////////////////
    // Engine state machine
    logic [1:0] minor_state_reg;
    logic [1:0] minor_next;
    logic [3:0] bit_counter;
    logic [3:0] count_next;
    logic [7:0] shift_reg;
    logic [7:0] shift_next;
    logic       addr_phase_reg;
    logic       addr_phase_next;
    logic       sda_drive_reg;
    logic       sda_drive_next;
    logic       scl_drive_reg;
    logic       scl_drive_next;
    logic       reading_next;
    logic       starved_next;
    logic [3:0] store_idx_reg;
    logic [3:0] store_idx_next;
    logic       rx_done;
    logic       valid_used;

    wire addr_match = (shift_reg[7:1] == slave_addr_reg);
    wire [4:0] store_limit = (store_count_reg == 5'h00 || store_count_reg > 5'(STORE_DEPTH)) ?
                             5'(STORE_DEPTH) : store_count_reg;
    wire [3:0] idx_wrap = (5'(store_idx_reg) + 5'h01 >= store_limit) ? 4'h0 : store_idx_reg + 4'h1;

    always_comb begin
        state_next = main_state_reg;
        after_ack_next = after_ack_reg;
        minor_next = minor_state_reg;
        count_next = bit_counter;
        shift_next = shift_reg;
        addr_phase_next = addr_phase_reg;
        sda_drive_next = sda_drive_reg;
        scl_drive_next = scl_drive_reg;
        reading_next = master_reading_flag;
        starved_next = tx_starved_flag;
        store_idx_next = store_idx_reg;
        rx_done = 1'b0;
        valid_used = 1'b0;
        unique case (main_state_reg)
            i2c_slave_pkg::st_quiet: begin
                if (start_seen) state_next = i2c_slave_pkg::st_await_clock_low; // RULE7
            end
            i2c_slave_pkg::st_await_clock_low: begin
                if (!scl_s) state_next = i2c_slave_pkg::st_prep_addr_capture; // RULE8
            end
            i2c_slave_pkg::st_prep_addr_capture: begin
                count_next = i2c_slave_pkg::BIT_COUNT_PRESET; // RULE9
                addr_phase_next = 1'b1;
                state_next = i2c_slave_pkg::st_shift_in;
            end
            i2c_slave_pkg::st_prep_data_capture: begin
                count_next = i2c_slave_pkg::BIT_COUNT_PRESET; // RULE9
                addr_phase_next = 1'b0;
                state_next = i2c_slave_pkg::st_shift_in;
            end
            i2c_slave_pkg::st_shift_in: begin
                if (scl_rise) begin
                    shift_next = {shift_reg[6:0], sda_s}; // RULE18
                    count_next = bit_counter - 4'h1;
                    if (bit_counter == 4'h1) // RULE9
                        state_next = addr_phase_reg ? i2c_slave_pkg::st_addr_check : i2c_slave_pkg::st_store_rx;
                end
            end
            i2c_slave_pkg::st_addr_check: begin
                minor_next = 2'h0;
                if (addr_match) begin // RULE1
                    reading_next = shift_reg[0]; // RULE4
                    after_ack_next = shift_reg[0] ? i2c_slave_pkg::st_prep_shift_out :
                                                    i2c_slave_pkg::st_prep_data_capture; // RULE10
                    state_next = i2c_slave_pkg::st_drive_ack;
                end else begin
                    state_next = i2c_slave_pkg::st_return_quiet; // RULE10
                end
            end
            i2c_slave_pkg::st_store_rx: begin
                rx_done = 1'b1; // RULE12
                minor_next = 2'h0;
                after_ack_next = i2c_slave_pkg::st_prep_data_capture;
                state_next = i2c_slave_pkg::st_drive_ack;
            end
            i2c_slave_pkg::st_drive_ack: begin
                // Wait out the eighth clock high, hold SDA low over one full pulse
                if (minor_state_reg == 2'h0 && !scl_s) begin
                    sda_drive_next = 1'b1; // RULE11
                    minor_next = 2'h1;
                end else if (minor_state_reg == 2'h1 && scl_rise) begin
                    minor_next = 2'h2;
                end else if (minor_state_reg == 2'h2 && scl_fall) begin
                    sda_drive_next = 1'b0;
                    state_next = after_ack_reg;
                end
            end
            i2c_slave_pkg::st_prep_shift_out: begin
                count_next = i2c_slave_pkg::BIT_COUNT_PRESET; // RULE13
                minor_next = 2'h1;
                if (store_mode_reg) begin
                    shift_next = store_mem[store_idx_reg]; // RULE2
                    store_idx_next = idx_wrap;
                    sda_drive_next = !store_mem[store_idx_reg][7];
                    state_next = i2c_slave_pkg::st_shift_out;
                end else if (tx_valid_flag) begin
                    shift_next = tx_holding_reg; // RULE5
                    valid_used = 1'b1;
                    starved_next = 1'b0;
                    scl_drive_next = 1'b0;
                    sda_drive_next = !tx_holding_reg[7]; // RULE20
                    state_next = i2c_slave_pkg::st_shift_out;
                end else begin
                    starved_next = 1'b1; // RULE6
                    scl_drive_next = 1'b1; // RULE6
                end
            end
            i2c_slave_pkg::st_shift_out: begin
                if (minor_state_reg == 2'h1 && scl_rise) begin
                    minor_next = 2'h2;
                end else if (minor_state_reg == 2'h2 && scl_fall) begin
                    count_next = bit_counter - 4'h1; // RULE13
                    minor_next = 2'h1;
                    if (bit_counter == 4'h1) begin
                        sda_drive_next = 1'b0;
                        minor_next = 2'h0;
                        state_next = i2c_slave_pkg::st_sample_ack;
                    end else begin
                        shift_next = {shift_reg[6:0], 1'b0};
                        sda_drive_next = !shift_reg[6]; // RULE18
                    end
                end
            end
            i2c_slave_pkg::st_sample_ack: begin
                if (minor_state_reg == 2'h0 && scl_rise) begin
                    minor_next = sda_s ? 2'h2 : 2'h1;
                end else if (minor_state_reg != 2'h0 && scl_fall) begin
                    state_next = (minor_state_reg == 2'h1) ? i2c_slave_pkg::st_prep_shift_out :
                                                             i2c_slave_pkg::st_return_quiet; // RULE14
                end
            end
            i2c_slave_pkg::st_return_quiet: begin
                sda_drive_next = 1'b0;
                scl_drive_next = 1'b0;
                starved_next = 1'b0;
                state_next = i2c_slave_pkg::st_quiet;
            end
            default: begin
                state_next = i2c_slave_pkg::st_return_quiet;
            end
        endcase
        // Repeated start restarts address capture; stop always wins
        if (start_seen && main_state_reg != i2c_slave_pkg::st_quiet) begin
            state_next = i2c_slave_pkg::st_await_clock_low;
            sda_drive_next = 1'b0;
            scl_drive_next = 1'b0;
        end
        if (stop_seen) begin
            state_next = i2c_slave_pkg::st_quiet; // RULE19
            sda_drive_next = 1'b0; // RULE19
            scl_drive_next = 1'b0; // RULE19
            starved_next = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (engine_initialise) begin // RULE16
            main_state_reg <= i2c_slave_pkg::st_quiet;
            after_ack_reg <= i2c_slave_pkg::st_quiet;
            minor_state_reg <= 2'h0;
            bit_counter <= 4'h0;
            shift_reg <= 8'h00;
            addr_phase_reg <= 1'b0;
            sda_drive_reg <= 1'b0;
            scl_drive_reg <= 1'b0;
            master_reading_flag <= 1'b0;
            tx_starved_flag <= 1'b0;
            store_idx_reg <= 4'h0;
        end else if (tick) begin // RULE15
            main_state_reg <= state_next;
            after_ack_reg <= after_ack_next;
            minor_state_reg <= minor_next;
            bit_counter <= count_next;
            shift_reg <= shift_next;
            addr_phase_reg <= addr_phase_next;
            sda_drive_reg <= sda_drive_next;
            scl_drive_reg <= scl_drive_next;
            master_reading_flag <= reading_next;
            tx_starved_flag <= starved_next;
            store_idx_reg <= store_idx_next;
        end
    end

    // Hardware set beats software clear in the same cycle
    always_ff @(posedge clk) begin
        if (engine_initialise) begin
            byte_received_flag <= 1'b0;
            slave_event_flag <= 1'b0;
            tx_valid_flag <= 1'b0;
            rx_holding_reg <= 8'h00;
        end else begin
            if (tick && rx_done) rx_holding_reg <= shift_reg; // RULE12
            byte_received_flag <= (tick && rx_done) || (byte_received_flag && !clr_rx); // RULE12
            slave_event_flag <= (tick && rx_done) || (slave_event_flag && !clr_event); // RULE12
            tx_valid_flag <= set_valid || (tx_valid_flag && !(tick && valid_used)); // RULE5
        end
    end

    // Open drain: output level fixed low, only the enable moves
    assign data_line_pin_out = 1'b0; // RULE20
    assign clock_line_pin_out = 1'b0; // RULE20
    assign data_line_pin_oe_n = !sda_drive_reg; // RULE20
    assign clock_line_pin_oe_n = !scl_drive_reg; // RULE20

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (engine_initialise);

    a_other_addr_ignored: assert property ( // RULE1
        tick && main_state_reg == i2c_slave_pkg::st_addr_check && !addr_match && !stop_seen && !start_seen
        |=> main_state_reg == i2c_slave_pkg::st_return_quiet ##[1:30] main_state_reg == i2c_slave_pkg::st_quiet)
        else $error("unmatched address not ignored");
    a_quiet_until_start: assert property ( // RULE7
        main_state_reg == i2c_slave_pkg::st_quiet && !start_seen |=> main_state_reg == i2c_slave_pkg::st_quiet)
        else $error("left quiet without start");
    a_wait_clock_low: assert property ( // RULE8
        main_state_reg == i2c_slave_pkg::st_await_clock_low && scl_s && !stop_seen
        |=> main_state_reg == i2c_slave_pkg::st_await_clock_low)
        else $error("address capture began with SCL high");
    a_count_preset: assert property ( // RULE9
        $rose(main_state_reg == i2c_slave_pkg::st_shift_in) |-> bit_counter == 4'h8)
        else $error("bit counter not preset to 8");
    a_rx_store_flags: assert property ( // RULE12
        tick && main_state_reg == i2c_slave_pkg::st_store_rx
        |=> byte_received_flag && slave_event_flag && rx_holding_reg == $past(shift_reg))
        else $error("received byte not stored with flags");
    a_ack_holds_sda: assert property ( // RULE11
        main_state_reg == i2c_slave_pkg::st_drive_ack && minor_state_reg != 2'h0 |-> !data_line_pin_oe_n)
        else $error("SDA released during acknowledge");
    a_starve_stretch: assert property ( // RULE6
        tx_starved_flag && main_state_reg == i2c_slave_pkg::st_prep_shift_out |-> !clock_line_pin_oe_n)
        else $error("SCL not held while starved");
    a_stop_releases: assert property ( // RULE19
        stop_seen |=> main_state_reg == i2c_slave_pkg::st_quiet && data_line_pin_oe_n && clock_line_pin_oe_n)
        else $error("stop did not release the bus");
    a_tick_spacing: assert property ( // RULE15
        tick |=> !tick [*8])
        else $error("step tick too frequent");
    a_nack_ends_read: assert property ( // RULE14
        tick && main_state_reg == i2c_slave_pkg::st_sample_ack && minor_state_reg == 2'h2 && scl_fall
        && !start_seen && !stop_seen |=> main_state_reg == i2c_slave_pkg::st_return_quiet)
        else $error("no-ack did not end transmit");

    c_write_byte: cover property (tick && main_state_reg == i2c_slave_pkg::st_store_rx);
    c_read_byte: cover property (tick && main_state_reg == i2c_slave_pkg::st_sample_ack && scl_fall);
    c_stretch: cover property (tx_starved_flag && scl_drive_reg);
endmodule // i2c_slave_engine
`default_nettype wire

//--- i2c_master_model.sv
// Purpose: I2C bus master model. Assumes: pull-ups, 1 us tick. Notes: outputs ask for a line low
`timescale 1ns/1ns
`default_nettype none
module i2c_master_model (
    input  wire logic clk,
    input  wire logic scl,
    input  wire logic sda,
    output logic      scl_low,
    output logic      sda_low
);
    initial {scl_low, sda_low} = 2'b00;
    // SDA moves mid-low, sampled late in high; stretch wait is bounded
    task automatic put(input logic b, output logic r);
        scl_low <= 1'b1;
        repeat (60) @(posedge clk);
        sda_low <= !b;
        repeat (65) @(posedge clk);
        scl_low <= 1'b0;
        for (int n = 0; n < 30000 && !scl; n++) @(posedge clk);
        repeat (125) @(posedge clk);
        r = sda;
    endtask
    task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic a);
        for (int i = 7; i >= 0; i--) put(d[i], q[i]);
        put(1'b1, a);
    endtask
    // A read always ends on no-ACK after one byte
    task automatic txn(input logic [7:0] ab, db, output logic [7:0] q, output logic aa, da);
        logic u;
        put(1'b1, u);
        sda_low <= 1'b1;
        repeat (125) @(posedge clk);
        xfer(ab, q, aa);
        if (!aa) xfer(db, q, da);
        put(1'b0, u);
        sda_low <= 1'b0;
        repeat (125) @(posedge clk);
    endtask
endmodule // i2c_master_model
`default_nettype wire

//--- tb_top.sv
// Purpose: I2C slave bench. Assumes: master model on bus. Notes: seeded random address and data
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    localparam logic [7:0] ST = i2c_slave_pkg::ADDR_STATUS;
    logic        clk = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0, sda_o, scl_o, sda_oe_n, scl_oe_n;
    logic        m_scl, m_sda, aa, da;
    logic [7:0]  reg_addr = 8'h00, q, d;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic [6:0]  sa;
    int          n_fail = 0, checks = 0;
    wire         scl = scl_oe_n & !m_scl;
    wire         sda = sda_oe_n & !m_sda;
    i2c_slave_engine i2c_slave_engine_inst (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .data_line_pin_in(sda),
        .data_line_pin_out(sda_o), .data_line_pin_oe_n(sda_oe_n), .clock_line_pin_in(scl),
        .clock_line_pin_out(scl_o), .clock_line_pin_oe_n(scl_oe_n));
    i2c_master_model i2c_master_model_inst (.clk(clk), .scl(scl), .sda(sda), .scl_low(m_scl), .sda_low(m_sda));
    task automatic chk(input logic [31:0] g, e);
        checks++;
        if (g !== e) begin n_fail++; $display("Error at %0t ns: got %h, expected %h", $time, g, e); end
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        {reg_addr, reg_wdata, reg_write, reg_read} <= {a, v, w, !w};
        @(posedge clk);
        {reg_write, reg_read} <= 2'b00;
        #1 if (!w) chk(reg_rdata, v);
    endtask
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial forever #20 clk = ~clk;
    // Traffic needs about 30k cycles
    initial begin repeat (100000) @(posedge clk); n_fail++; conclude(); end
    initial begin
        void'($urandom(87722));
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        acc(1'b0, i2c_slave_pkg::ADDR_CTRL, 32'h20);
        acc(1'b0, ST, 32'h0);
        acc(1'b0, 8'hF0, 32'h0);
        sa = 7'($urandom);
        acc(1'b1, i2c_slave_pkg::ADDR_CTRL, {25'h0, sa});
        $display("register test done");
        for (int k = 0; k < 3; k++) begin
            d = 8'($urandom);
            i2c_master_model_inst.txn({sa, 1'b0}, d, q, aa, da);
            chk(da, 1'b0);
            acc(1'b0, i2c_slave_pkg::ADDR_RX_DATA, {24'h0, d});
            acc(1'b0, ST, 32'h3);
            acc(1'b1, ST, 32'h3);
        end
        $display("write test done");
        i2c_master_model_inst.txn({sa ^ 7'h01, 1'b0}, 8'h00, q, aa, da);
        chk(aa, 1'b1);
        acc(1'b0, ST, 32'h0);
        $display("foreign address test done");
        fork
            i2c_master_model_inst.txn({sa, 1'b1}, 8'hFF, q, aa, da);
            begin
                repeat (3000) @(posedge clk);
                chk(scl, 1'b0);
                acc(1'b0, ST, 32'h34);
                acc(1'b1, i2c_slave_pkg::ADDR_TX_DATA, 32'hA5);
                acc(1'b1, ST, 32'h8);
            end
        join
        chk(q, 8'hA5);
        acc(1'b0, ST, 32'h4);
        $display("read test done");
        d = 8'($urandom);
        acc(1'b1, i2c_slave_pkg::ADDR_STORE_BASE, {24'h0, d});
        acc(1'b1, i2c_slave_pkg::ADDR_CTRL, {22'h0, 2'b11, 1'b0, sa});
        acc(1'b0, ST, 32'h0);
        i2c_master_model_inst.txn({sa, 1'b1}, 8'hFF, q, aa, da);
        chk(q, d);
        chk({sda_o, scl_o}, 2'b00);
        $display("store read test done");
        conclude();
    end
endmodule // tb_top
`default_nettype wire
